// ===== verilog/adc_lvds_output_port.sv
// digital output port of a pipelined 16-bit converter: mode pins, saturation, forwarded clock
// assumes the core result arrives on sampleClk; pins are asynchronous to both clocks
`timescale 1ns/1ps
module adc_lvds_output_port
  import adc_port_pkg::*;
#(
  parameter int RAW_BITS = 18
) (
  // control clock and reset
  input wire logic sys_clk,
  input wire logic rst_n,
  // sampling clock and core result in its domain
  input wire logic sampleClk,
  input wire logic [RAW_BITS-1:0] rawSample,
  // mode pins, asynchronous
  input wire logic [1:0] powerModePin,
  input wire logic [1:0] clockAndFormatSelectPin,
  // output port, sampleClk domain
  output logic [adc_port_pkg::WORD_BITS-1:0] sampleWordOut,
  output logic overRange,
  output logic forwardedWordClock,
  // status, sys_clk domain
  output logic powerDownActive,
  output logic sleepActive,
  output logic conversionRunning,
  output logic singleEndedClockSel,
  output logic twosComplementSel
);

  import adc_port_pkg::*;

  if (RAW_BITS < WORD_BITS + 2) begin : g_bad_width
    $error("RAW_BITS must leave a sign bit and an overflow bit above the word");
  end

  // ****************************************************************
  // control domain: pin capture and mode decode
  // ****************************************************************
  typedef enum logic [1:0] {ST_RUN, ST_LOW, ST_WAKE} wake_state_e;

  logic [1:0] pwrSync;
  logic [1:0] cfgSync;
  wake_state_e state_q;
  logic [WAKE_CNT_BITS-1:0] wakeCnt_q;
  power_mode_e lastLow_q;
  power_mode_e target;

  // the spare fourth comparator code is taken as power-down, the safe side
  function automatic power_mode_e decodePower(input logic [1:0] code);
    case (code)
      PWR_PIN_GROUND: decodePower = PM_NORMAL;
      PWR_PIN_TWO_THIRDS: decodePower = PM_SLEEP;
      default: decodePower = PM_POWER_DOWN;
    endcase
  endfunction

  level_sync #(.WIDTH(2), .RESET_VAL(PWR_PIN_GROUND)) u_pwr_sync (
    .clk(sys_clk),
    .rstN(rst_n),
    .asyncIn(powerModePin),
    .syncOut(pwrSync)
  );

  level_sync #(.WIDTH(2), .RESET_VAL(CFG_PIN_RESET)) u_cfg_sync (
    .clk(sys_clk),
    .rstN(rst_n),
    .asyncIn(clockAndFormatSelectPin),
    .syncOut(cfgSync)
  );

  assign target = decodePower(pwrSync);

  // wake sequencer: power-down waits longer than sleep before conversion resumes
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      state_q <= ST_RUN;
      wakeCnt_q <= '0;
      lastLow_q <= PM_NORMAL;
    end else begin
      case (state_q)
        ST_RUN: begin
          if (target != PM_NORMAL) begin
            state_q <= ST_LOW;
            lastLow_q <= target;
          end
        end
        ST_LOW: begin
          lastLow_q <= target;
          if (target == PM_NORMAL) begin
            state_q <= ST_WAKE;
            wakeCnt_q <= (lastLow_q == PM_SLEEP) ? WAKE_CNT_BITS'(SLEEP_RECOVERY_CYC - 1)
                                                 : WAKE_CNT_BITS'(PD_RECOVERY_CYC - 1);
          end
        end
        ST_WAKE: begin
          if (target != PM_NORMAL) begin
            state_q <= ST_LOW;
            lastLow_q <= target;
          end else if (wakeCnt_q == '0) begin
            state_q <= ST_RUN;
          end else begin
            wakeCnt_q <= wakeCnt_q - 1'b1;
          end
        end
        default: begin
          state_q <= ST_RUN;
        end
      endcase
    end
  end

  // status flops; the running bit is what enables the link domain
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      powerDownActive <= 1'b0;
      sleepActive <= 1'b0;
      conversionRunning <= 1'b0;
    end else begin
      powerDownActive <= (target == PM_POWER_DOWN);
      sleepActive <= (target == PM_SLEEP);
      conversionRunning <= (state_q == ST_RUN) && (target == PM_NORMAL);
    end
  end

  // configuration settings from the four-level pin
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      singleEndedClockSel <= 1'b0;
      twosComplementSel <= 1'b0;
    end else begin
      singleEndedClockSel <= cfgSync[CFG_CLKSEL_BIT];
      twosComplementSel <= cfgSync[CFG_FORMAT_BIT];
    end
  end

  // ****************************************************************
  // link domain: saturation, output register, forwarded clock
  // ****************************************************************
  logic linkRstN;
  logic [1:0] linkCtl;
  logic runLink;
  logic twosLink;
  logic [WORD_BITS-1:0] satWord;
  logic satOver;
  logic riseTgl_q;
  logic fallTgl_q;

  // reset release is brought across so the link flops leave reset cleanly
  level_sync #(.WIDTH(1), .RESET_VAL(1'b0)) u_rst_sync (
    .clk(sampleClk),
    .rstN(1'b1),
    .asyncIn(rst_n),
    .syncOut(linkRstN)
  );

  // both are static levels; a one-cycle skew between them is harmless
  level_sync #(.WIDTH(2), .RESET_VAL(2'b00)) u_ctl_sync (
    .clk(sampleClk),
    .rstN(linkRstN),
    .asyncIn({conversionRunning, twosComplementSel}),
    .syncOut(linkCtl)
  );

  assign runLink = linkCtl[1];
  assign twosLink = linkCtl[0];

  // clamp to the code range and flag anything outside it
  always_comb begin
    satWord = rawSample[WORD_BITS-1:0];
    satOver = 1'b0;
    if (rawSample[RAW_BITS-1]) begin
      satWord = UNDER_RANGE_CODE;
      satOver = 1'b1;
    end else if (|rawSample[RAW_BITS-2:WORD_BITS]) begin
      satWord = OVER_RANGE_CODE;
      satOver = 1'b1;
    end
  end

  // word and flag share one register stage so they never drift apart
  always_ff @(posedge sampleClk) begin
    if (!linkRstN) begin
      sampleWordOut <= WORD_RESET;
      overRange <= 1'b0;
    end else if (runLink) begin
      sampleWordOut <= twosLink ? (satWord ^ SIGN_FLIP_MASK) : satWord;
      overRange <= satOver;
    end
  end

  // forwarded clock rises on the falling sample edge, mid-way through the data eye
  always_ff @(posedge sampleClk) begin
    if (!linkRstN) begin
      riseTgl_q <= 1'b0;
    end else if (runLink) begin
      riseTgl_q <= ~riseTgl_q;
    end
  end

  // follower on the other edge; when frozen it catches up and the clock rests high
  always_ff @(negedge sampleClk) begin
    if (!linkRstN) begin
      fallTgl_q <= 1'b0;
    end else begin
      fallTgl_q <= riseTgl_q;
    end
  end

  // one word per period: low after each word update, high from the next falling edge
  assign forwardedWordClock = ~(riseTgl_q ^ fallTgl_q);

  // ****************************************************************
  // checks
  // ****************************************************************
  a_under_range_zero: assert property (@(posedge sampleClk) disable iff (!linkRstN)
    runLink && !twosLink && rawSample[RAW_BITS-1] |=> sampleWordOut == 16'h0000 && overRange)
    else $error("under-range sample did not give zero code with flag");

  a_over_range_max: assert property (@(posedge sampleClk) disable iff (!linkRstN)
    runLink && !twosLink && !rawSample[RAW_BITS-1] && (|rawSample[RAW_BITS-2:WORD_BITS])
    |=> sampleWordOut == 16'hFFFF && overRange)
    else $error("over-range sample did not give full code with flag");

  a_in_range_word: assert property (@(posedge sampleClk) disable iff (!linkRstN)
    runLink && !twosLink && rawSample[RAW_BITS-1:WORD_BITS] == '0
    |=> sampleWordOut == $past(rawSample[WORD_BITS-1:0]) && !overRange)
    else $error("in-range word not passed through whole");

  a_flag_word_align: assert property (@(posedge sampleClk) disable iff (!linkRstN)
    overRange && !twosLink && $past(!twosLink) |-> sampleWordOut == 16'h0000 || sampleWordOut == 16'hFFFF)
    else $error("over-range flag not aligned with saturated word");

  a_stopped_holds: assert property (@(posedge sampleClk) disable iff (!linkRstN)
    !runLink |=> $stable(sampleWordOut) && $stable(overRange) && $stable(riseTgl_q))
    else $error("output moved while conversion stopped");

  a_clock_per_word: assert property (@(posedge sampleClk) disable iff (!linkRstN)
    runLink |=> riseTgl_q != $past(riseTgl_q) ##1 forwardedWordClock)
    else $error("forwarded clock did not complete one period per word");

  a_power_down_decode: assert property (@(posedge sys_clk) disable iff (!rst_n)
    pwrSync == PWR_PIN_SUPPLY |=> powerDownActive && !sleepActive && !conversionRunning)
    else $error("supply level did not select power-down");

  a_sleep_decode: assert property (@(posedge sys_clk) disable iff (!rst_n)
    pwrSync == PWR_PIN_TWO_THIRDS |=> sleepActive && !powerDownActive && !conversionRunning)
    else $error("two-thirds level did not select sleep");

  // sleep recovery of eight cycles: entry tick, eight ground ticks, then running is seen
  // the lastLow_q flop already reads normal on the entry tick, so the loaded count tells sleep apart
  a_normal_resumes: assert property (@(posedge sys_clk) disable iff (!rst_n)
    $rose(state_q == ST_WAKE) && wakeCnt_q == WAKE_CNT_BITS'(SLEEP_RECOVERY_CYC - 1)
    && pwrSync == PWR_PIN_GROUND ##1 (pwrSync == PWR_PIN_GROUND) [*8]
    |=> conversionRunning)
    else $error("normal mode not resumed after sleep recovery");

  a_format_decode: assert property (@(posedge sys_clk) disable iff (!rst_n)
    ##1 twosComplementSel == $past(cfgSync[CFG_FORMAT_BIT])
    && singleEndedClockSel == $past(cfgSync[CFG_CLKSEL_BIT]))
    else $error("select pin settings not decoded");

  c_over_range: cover property (@(posedge sampleClk) disable iff (!linkRstN) runLink && overRange);
  c_twos_word: cover property (@(posedge sampleClk) disable iff (!linkRstN) runLink && twosLink);
  c_sleep_wake: cover property (@(posedge sys_clk) disable iff (!rst_n)
    sleepActive ##1 !sleepActive ##[1:20] conversionRunning);
  c_power_down: cover property (@(posedge sys_clk) disable iff (!rst_n) $rose(powerDownActive));

endmodule

// ===== verilog/adc_port_pkg.sv
// shared constants and types for the converter output port
// assumes the port, the capture model and the testbench import this package
package adc_port_pkg;

  // ****************************************************************
  // word layout and saturation codes
  // ****************************************************************
  localparam int WORD_BITS = 16;
  localparam logic [WORD_BITS-1:0] UNDER_RANGE_CODE = 16'h0000;
  localparam logic [WORD_BITS-1:0] OVER_RANGE_CODE = 16'hFFFF;
  localparam logic [WORD_BITS-1:0] SIGN_FLIP_MASK = 16'h8000;
  localparam logic [WORD_BITS-1:0] WORD_RESET = 16'h0000;

  // ****************************************************************
  // pin level codes
  // ****************************************************************
  // power-mode pin as seen through its level comparators
  localparam logic [1:0] PWR_PIN_GROUND = 2'h0;
  localparam logic [1:0] PWR_PIN_TWO_THIRDS = 2'h1;
  localparam logic [1:0] PWR_PIN_SUPPLY = 2'h2;
  // four-level select pin: one bit per setting
  localparam int CFG_FORMAT_BIT = 0;
  localparam int CFG_CLKSEL_BIT = 1;
  localparam logic [1:0] CFG_PIN_RESET = 2'h0;

  // ****************************************************************
  // recovery timing
  // ****************************************************************
  localparam int SYS_CLK_PERIOD_NS = 100;
  localparam int PD_RECOVERY_NS = 3200;
  localparam int SLEEP_RECOVERY_NS = 800;
  // least times, so round up
  localparam int PD_RECOVERY_CYC = (PD_RECOVERY_NS + SYS_CLK_PERIOD_NS - 1) / SYS_CLK_PERIOD_NS;
  localparam int SLEEP_RECOVERY_CYC = (SLEEP_RECOVERY_NS + SYS_CLK_PERIOD_NS - 1) / SYS_CLK_PERIOD_NS;
  localparam int WAKE_CNT_BITS = 8;

  typedef enum logic [1:0] {PM_NORMAL, PM_SLEEP, PM_POWER_DOWN} power_mode_e;

endpackage

// ===== verilog/level_sync.sv
// two-flop synchroniser for slow levels
// assumes each bit is independent or held steady long enough to settle
`timescale 1ns/1ps
module level_sync #(
  parameter int WIDTH = 1,
  parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
  // clock and reset of the receiving domain
  input wire logic clk,
  input wire logic rstN,
  // levels
  input wire logic [WIDTH-1:0] asyncIn,
  output logic [WIDTH-1:0] syncOut
);

  logic [WIDTH-1:0] meta_q;

  // first stage feeds only the second stage
  always_ff @(posedge clk) begin
    if (!rstN) begin
      meta_q <= RESET_VAL;
      syncOut <= RESET_VAL;
    end else begin
      meta_q <= asyncIn;
      syncOut <= meta_q;
    end
  end

endmodule

// ===== sim/lvds_capture_model.sv
// receiving capture logic at the far end of the converter output port
// assumes word and flag are settled at each forwarded clock rising edge
`timescale 1ns/1ps
module lvds_capture_model
  import adc_port_pkg::*;
(
  // forwarded clock and data pairs
  input wire logic forwardedWordClock,
  input wire logic [adc_port_pkg::WORD_BITS-1:0] sampleWordOut,
  input wire logic overRange,
  // what the receiver took
  output logic [adc_port_pkg::WORD_BITS-1:0] gotWord,
  output logic gotFlag,
  output int unsigned captureCount
);
  // ****************************************************************
  // capture
  // ****************************************************************
  // one driver for the count: a local variable with a start value
  int unsigned count_q = 0;
  assign captureCount = count_q;
  // rising edge only: the port moves the word near the falling edge
  always @(posedge forwardedWordClock) begin
    gotWord <= sampleWordOut;
    gotFlag <= overRange;
    count_q <= count_q + 1;
  end
endmodule

// ===== sim/test_adc_lvds_output_port.sv
// testbench for the converter output port
// assumes the capture model samples on the forwarded clock
`timescale 1ns/1ps
module test_adc_lvds_output_port;
  import adc_port_pkg::*;
  // ****************************************************************
  // signals, clocks, instances
  // ****************************************************************
  logic sys_clk = 1'b0;
  logic sampleClk = 1'b0;
  logic rst_n = 1'b0;
  logic [17:0] rawSample = 18'h0_0000;
  logic [1:0] powerModePin = 2'h0;
  logic [1:0] clockAndFormatSelectPin = 2'h0;
  logic [WORD_BITS-1:0] sampleWordOut, gotWord;
  logic overRange, forwardedWordClock, powerDownActive, sleepActive;
  logic conversionRunning, singleEndedClockSel, twosComplementSel, gotFlag;
  int unsigned captureCount, base;
  int err_total = 0;
  int tests_run = 0;
  logic [17:0] raws [5] = '{18'h0_1234, 18'h0_0000, 18'h0_FFFF, 18'h1_0000, 18'h3_FFFF};
  logic [15:0] words [5] = '{16'h1234, 16'h0000, 16'hFFFF, OVER_RANGE_CODE, UNDER_RANGE_CODE};
  logic flags [5] = '{1'b0, 1'b0, 1'b0, 1'b1, 1'b1};

  // system clock, 100 ns
  initial forever #50 sys_clk = ~sys_clk;
  // sampling clock, 160 ns, offset so its edges never meet sys_clk edges
  initial begin
    #37;
    forever #80 sampleClk = ~sampleClk;
  end

  adc_lvds_output_port #(.RAW_BITS(18)) DUT (.sys_clk(sys_clk), .rst_n(rst_n), .sampleClk(sampleClk),
    .rawSample(rawSample), .powerModePin(powerModePin), .clockAndFormatSelectPin(clockAndFormatSelectPin),
    .sampleWordOut(sampleWordOut), .overRange(overRange), .forwardedWordClock(forwardedWordClock),
    .powerDownActive(powerDownActive), .sleepActive(sleepActive), .conversionRunning(conversionRunning),
    .singleEndedClockSel(singleEndedClockSel), .twosComplementSel(twosComplementSel));
  lvds_capture_model rx (.forwardedWordClock(forwardedWordClock), .sampleWordOut(sampleWordOut),
    .overRange(overRange), .gotWord(gotWord), .gotFlag(gotFlag), .captureCount(captureCount));

  // ****************************************************************
  // tasks
  // ****************************************************************
  task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
    tests_run++;
    if (got !== exp) begin
      err_total++;
      $display("[ERR] %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  task automatic sys_wait(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask

  // one raw result through the port, judged by what the receiver captured
  task automatic send(input logic [17:0] raw, input logic [15:0] word, input logic flag);
    @(posedge sampleClk) rawSample <= raw;
    repeat (2) @(posedge sampleClk);
    @(negedge sampleClk);
    #1;
    chk(gotWord, word, "captured word");
    chk({15'h0, gotFlag}, {15'h0, flag}, "captured flag");
  endtask

  // captures over n sampling periods; a stopped port must give none
  task automatic count_words(input int n, input int exp);
    @(negedge sampleClk);
    #1;
    base = captureCount;
    repeat (n) @(negedge sampleClk);
    #1;
    chk(16'(captureCount - base), 16'(exp), "words per period");
  endtask

  task automatic give_verdict();
    $display("errors %0d checks %0d", err_total, tests_run);
    if (err_total == 0 && tests_run > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  // ****************************************************************
  // test sequence
  // ****************************************************************
  // three reset cycles outlast one sampling period, so the link synchroniser still catches them
  initial begin
    int rec;
    repeat (2) @(posedge sys_clk);
    @(posedge sys_clk) rst_n <= 1'b1;
    sys_wait(3);
    // link side is reset and not yet enabled: word cleared, forwarded clock resting high
    chk(sampleWordOut, WORD_RESET, "word after reset");
    chk({15'h0, forwardedWordClock}, 16'h0001, "clock rest level");
    chk({13'h0, conversionRunning, sleepActive, powerDownActive}, 16'h0004, "normal after reset");
    sys_wait(10);
    count_words(12, 12);
    // both formats, select bits driven both ways
    for (int f = 0; f < 2; f++) begin
      @(posedge sys_clk) clockAndFormatSelectPin <= (f == 1) ? 2'h1 : 2'h2;
      sys_wait(12);
      chk({14'h0, singleEndedClockSel, twosComplementSel}, (f == 1) ? 16'h0001 : 16'h0002, "select");
      for (int i = 0; i < 5; i++) begin
        send(raws[i], words[i] ^ ((f == 1) ? SIGN_FLIP_MASK : 16'h0000), flags[i]);
      end
    end
    // sleep, power-down and the spare code, each with its recovery
    for (int m = 1; m < 4; m++) begin
      rec = (m == 1) ? SLEEP_RECOVERY_CYC : PD_RECOVERY_CYC;
      @(posedge sys_clk) powerModePin <= 2'(m);
      sys_wait(6);
      chk({14'h0, sleepActive, powerDownActive}, (m == 1) ? 16'h0002 : 16'h0001, "low mode");
      chk({15'h0, conversionRunning}, 16'h0000, "stopped");
      sys_wait(6);
      count_words(8, 0);
      @(posedge sys_clk) powerModePin <= 2'h0;
      sys_wait(rec + 2);
      chk({15'h0, conversionRunning}, 16'h0000, "recovery too short");
      sys_wait(4);
      chk({15'h0, conversionRunning}, 16'h0001, "running again");
      sys_wait(10);
      count_words(8, 8);
      send(raws[3], OVER_RANGE_CODE ^ SIGN_FLIP_MASK, 1'b1);
    end
    give_verdict();
  end

  // cuts a hang short
  initial begin
    #3000000;
    err_total++;
    $display("[ERR] %0t watchdog expired", $time);
    give_verdict();
  end
endmodule
